// >>> core/ccs_clock_source_ctrl.sv
`timescale 1ns/100ps
module ccs_clock_source_ctrl #(
  parameter int LONG_TIMEOUT_CYCLES = ccs_pkg::DEF_LONG_TIMEOUT,
  parameter int LF_LONG_STARTUP = ccs_pkg::DEF_LF_LONG,
  parameter int LP_LONG_STARTUP = ccs_pkg::DEF_LP_LONG
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ccs_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic rc_osc_in,
  input wire logic xtal_osc_in,
  input wire logic wdt_osc_in,
  input wire logic [3:0] fuse_clock_source_select_in,
  input wire logic [1:0] fuse_startup_select_in,
  input wire logic fuse_divide_by_eight_in,
  input wire logic [7:0] factory_cal_in,
  input wire logic sleep_enter_in,
  input wire logic wake_in,
  output logic core_clk_en_out,
  output logic core_rstn_out,
  output logic wdt_tick_out,
  output logic [7:0] rc_trim_out,
  output logic rc_low_freq_out,
  output logic rc_osc_enable_out,
  output logic xtal_osc_enable_out,
  output logic clock_select_ext_out
);
  import ccs_pkg::*;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [SYNC_W-1:0] async_bus;
  logic [SYNC_W-1:0] sync_level;
  logic [SYNC_W-1:0] sync_rise;

  assign async_bus = {factory_cal_in, fuse_divide_by_eight_in, fuse_startup_select_in,
                      fuse_clock_source_select_in, wdt_osc_in, xtal_osc_in, rc_osc_in};

  ccs_edge_sync #(.WIDTH(SYNC_W)) u_sync (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .async_in(async_bus),
    .level_out(sync_level),
    .rise_out(sync_rise)
  );

  // Oscillators far above clock_in would alias; the sampled edges are the cycles counted
  wire rc_edge = sync_rise[SB_RC];
  wire xtal_edge = sync_rise[SB_XTAL];
  wire wdt_edge = sync_rise[SB_WDT];
  wire [3:0] fuse_css = sync_level[SB_CSS_LO +: 4];
  wire [1:0] fuse_sut = sync_level[SB_SUT_LO +: 2];
  wire fuse_div8 = sync_level[SB_DIV8];
  wire [7:0] fuse_cal = sync_level[SB_CAL_LO +: 8];

  // ----------------------------------------
  // Fuse decode
  // ----------------------------------------
  function automatic logic [1:0] kind_of(input logic [3:0] css);
    if (css[CSS_LP_BIT]) begin
      return KIND_LP;
    end else if ((css >> (CSS_LSB_BIT + 1)) == (CSS_LFXT >> (CSS_LSB_BIT + 1))) begin
      return KIND_LF;
    end
    return KIND_RCEXT;
  endfunction

  function automatic logic [15:0] osc_count(input logic [1:0] kind, input logic lsb, input logic [1:0] startup_select);
    logic [2:0] code;
    code = {lsb, startup_select};
    if (kind == KIND_LF) begin
      return lsb ? 16'(LF_LONG_STARTUP) : CNT_1K;
    end else if (kind == KIND_LP) begin
      unique case (code)
        3'h0, 3'h1: return CNT_LP_SHORT;
        3'h2, 3'h3, 3'h4: return CNT_1K;
        default: return 16'(LP_LONG_STARTUP);
      endcase
    end
    return CNT_RC_EXT_START;
  endfunction

  function automatic logic [15:0] timeout_count(input logic [1:0] kind, input logic lsb, input logic [1:0] startup_select);
    logic [2:0] code;
    code = {lsb, startup_select};
    if (kind == KIND_LP) begin
      unique case (code)
        3'h0, 3'h3, 3'h6: return CNT_TO_SHORT;
        3'h2, 3'h5: return CNT_NONE;
        default: return 16'(LONG_TIMEOUT_CYCLES);
      endcase
    end
    // Reserved code takes the longest delay rather than an undefined one
    unique case (startup_select)
      SUT_ZERO: return CNT_NONE;
      SUT_SHORT: return CNT_TO_SHORT;
      SUT_LONG, SUT_RSVD: return 16'(LONG_TIMEOUT_CYCLES);
    endcase
  endfunction

  wire [1:0] fuse_kind = kind_of(fuse_css);
  wire fuse_is_ext = (fuse_css != CSS_RC);

  // ----------------------------------------
  // Start-up sequencer
  // ----------------------------------------
  ccs_state_type state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] start_ff, ext_start_ff, timeout_ff;
  logic [1:0] kind_ff;
  logic wake_ff, div8_ff, core_rstn_ff, active_ext_ff, nxt_active_ext;
  logic [2:0] div_ff;
  logic core_clk_en_ff, wdt_tick_ff;
  wire [SRC_N-1:0] src_on;

  wire act_edge = active_ext_ff ? xtal_edge : rc_edge;
  wire [15:0] wake_start = active_ext_ff ? ext_start_ff : CNT_RC_EXT_START;
  wire [15:0] osc_target = wake_ff ? wake_start : start_ff;
  wire latch_done = (state_ff == ST_LATCH) && (cnt_ff == CNT_SETTLE - CNT_ONE);
  wire osc_done = (state_ff == ST_OSC) && act_edge && (cnt_ff == osc_target - CNT_ONE);
  wire tail_done = (state_ff == ST_TAIL) && act_edge && (cnt_ff == CNT_TAIL - CNT_ONE);
  // Time-out advances on watchdog edges only, whichever source runs the core
  wire to_done = (state_ff == ST_TIMEOUT) && wdt_edge && (cnt_ff == timeout_ff - CNT_ONE);
  wire cnt_tick = (state_ff == ST_LATCH) || ((state_ff == ST_OSC || state_ff == ST_TAIL) && act_edge) ||
                  ((state_ff == ST_TIMEOUT) && wdt_edge);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_LATCH: if (latch_done) begin
        nxt_state = ST_OSC;
      end
      ST_OSC: if (osc_done) begin
        nxt_state = wake_ff ? ST_RUN : ST_TAIL;
      end
      ST_TAIL: if (tail_done) begin
        nxt_state = (timeout_ff == CNT_NONE) ? ST_RUN : ST_TIMEOUT;
      end
      ST_TIMEOUT: if (to_done) begin
        nxt_state = ST_RUN;
      end
      ST_RUN: if (sleep_enter_in) begin
        nxt_state = ST_SLEEP;
      end
      ST_SLEEP: if (wake_in) begin
        nxt_state = ST_OSC;
      end
    endcase
  end

  assign nxt_cnt = (nxt_state != state_ff) ? CNT_NONE : (cnt_tick ? cnt_ff + CNT_ONE : cnt_ff);

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= ST_LATCH;
      cnt_ff <= CNT_NONE;
      wake_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      wake_ff <= (state_ff == ST_SLEEP) ? 1'b1 : ((nxt_state == ST_RUN) ? 1'b0 : wake_ff);
    end
  end

  // Fuses are caught once after reset release, never at the reset edge
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      kind_ff <= KIND_RCEXT;
      start_ff <= CNT_RC_EXT_START;
      ext_start_ff <= CNT_RC_EXT_START;
      timeout_ff <= CNT_NONE;
      div8_ff <= 1'b1;
    end else if (latch_done) begin
      kind_ff <= fuse_kind;
      start_ff <= osc_count(fuse_kind, fuse_css[CSS_LSB_BIT], fuse_sut);
      ext_start_ff <= fuse_is_ext ? osc_count(fuse_kind, fuse_css[CSS_LSB_BIT], fuse_sut) : CNT_RC_EXT_START;
      timeout_ff <= timeout_count(fuse_kind, fuse_css[CSS_LSB_BIT], fuse_sut);
      div8_ff <= fuse_div8;
    end
  end

  // ----------------------------------------
  // Core clock gate and prescaler
  // ----------------------------------------
  wire running = (state_ff == ST_RUN);
  wire div_hit = !div8_ff || (div_ff == DIV8_LAST);

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_ff <= 3'h0;
      core_clk_en_ff <= 1'b0;
      core_rstn_ff <= 1'b0;
      wdt_tick_ff <= 1'b0;
    end else begin
      div_ff <= !running ? 3'h0 : (act_edge ? div_ff + 3'h1 : div_ff);
      core_clk_en_ff <= running && act_edge && div_hit;
      core_rstn_ff <= core_rstn_ff || (nxt_state == ST_RUN);
      wdt_tick_ff <= wdt_edge;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff, rdata;
  logic [7:0] trim_ff;
  logic low_freq_ff, rc_en_ff, ext_en_ff, sel_ext_ff, sw_allowed_ff;
  logic rc_osc_en_ff, xtal_osc_en_ff;

  wire access = psel_in && penable_in;
  wire first_acc = access && !pready_ff;
  wire fire = access && pready_ff;
  wire hit_trim = (paddr_in == OFS_TRIM);
  wire hit_freq = (paddr_in == OFS_FREQ);
  wire hit_sw = (paddr_in == OFS_SWCTRL);
  wire hit_st = (paddr_in == OFS_STATUS);
  wire addr_hit = hit_trim || hit_freq || hit_sw || hit_st;
  wire lane0 = pstrb_in[STRB_LOW_LANE];
  wire wr_trim = fire && pwrite_in && hit_trim && lane0;
  wire wr_freq = fire && pwrite_in && hit_freq && lane0;
  wire wr_sw = fire && pwrite_in && hit_sw && lane0 && sw_allowed_ff;

  wire [31:0] rd_trim = 32'(trim_ff);
  wire [31:0] rd_freq = 32'(low_freq_ff) << FREQ_LOW_BIT;
  wire [31:0] rd_sw = (32'(rc_en_ff) << SW_RC_EN_BIT) | (32'(ext_en_ff) << SW_EXT_EN_BIT) |
                      (32'(sel_ext_ff) << SW_SEL_EXT_BIT);
  wire [31:0] rd_st = (32'(src_on[SRC_RC]) << ST_RC_ON_BIT) | (32'(src_on[SRC_EXT]) << ST_EXT_ON_BIT) |
                      (32'(active_ext_ff) << ST_ACT_EXT_BIT) | (32'(running) << ST_RUN_BIT);
  assign rdata = hit_trim ? rd_trim : hit_freq ? rd_freq : hit_sw ? rd_sw : hit_st ? rd_st : 32'h0;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= first_acc;
      pslverr_ff <= first_acc && !addr_hit;
      prdata_ff <= (first_acc && !pwrite_in) ? rdata : prdata_ff;
    end
  end

  // Trim drives the oscillator directly; the analog trim is monotonic in this code
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trim_ff <= 8'h00;
      low_freq_ff <= 1'b0;
    end else begin
      trim_ff <= latch_done ? fuse_cal : (wr_trim ? pwdata_in[7:0] : trim_ff);
      low_freq_ff <= wr_freq ? pwdata_in[FREQ_LOW_BIT] : low_freq_ff;
    end
  end

  // ----------------------------------------
  // Clock switch
  // ----------------------------------------
  wire [SRC_N-1:0] src_en = {xtal_osc_en_ff, rc_osc_en_ff};
  wire [SRC_N-1:0] src_edge = {xtal_edge, rc_edge};
  wire [15:0] src_target [SRC_N];
  assign src_target[SRC_RC] = CNT_RC_EXT_START;
  assign src_target[SRC_EXT] = ext_start_ff;

  for (genvar g = 0; g < SRC_N; g++) begin : g_src
    logic [15:0] on_cnt_ff;
    logic on_ff;
    always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
        on_cnt_ff <= CNT_NONE;
        on_ff <= 1'b0;
      end else if (!src_en[g]) begin
        on_cnt_ff <= CNT_NONE;
        on_ff <= 1'b0;
      end else if (src_edge[g] && !on_ff) begin
        on_cnt_ff <= on_cnt_ff + CNT_ONE;
        on_ff <= (on_cnt_ff == src_target[g] - CNT_ONE);
      end
    end
    assign src_on[g] = on_ff;
  end

  // Switch only once the target has counted its start-up; a running source stays enabled
  wire switch_go = running && (sel_ext_ff != active_ext_ff) && src_on[sel_ext_ff];
  assign nxt_active_ext = latch_done ? fuse_is_ext : (switch_go ? sel_ext_ff : active_ext_ff);

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rc_en_ff <= 1'b0;
      ext_en_ff <= 1'b0;
      sel_ext_ff <= 1'b0;
      sw_allowed_ff <= 1'b0;
      active_ext_ff <= 1'b0;
      rc_osc_en_ff <= 1'b0;
      xtal_osc_en_ff <= 1'b0;
    end else begin
      if (latch_done) begin
        rc_en_ff <= !fuse_is_ext;
        ext_en_ff <= fuse_is_ext;
        sel_ext_ff <= fuse_is_ext;
        sw_allowed_ff <= (fuse_kind != KIND_LF);
      end else if (wr_sw) begin
        rc_en_ff <= pwdata_in[SW_RC_EN_BIT];
        ext_en_ff <= pwdata_in[SW_EXT_EN_BIT];
        sel_ext_ff <= pwdata_in[SW_SEL_EXT_BIT];
      end
      active_ext_ff <= nxt_active_ext;
      rc_osc_en_ff <= (state_ff != ST_LATCH) && (rc_en_ff || !active_ext_ff);
      xtal_osc_en_ff <= (state_ff != ST_LATCH) && (ext_en_ff || active_ext_ff);
    end
  end

  assign pready_out = pready_ff;
  assign prdata_out = prdata_ff;
  assign pslverr_out = pslverr_ff;
  assign core_clk_en_out = core_clk_en_ff;
  assign core_rstn_out = core_rstn_ff;
  assign wdt_tick_out = wdt_tick_ff;
  assign rc_trim_out = trim_ff;
  assign rc_low_freq_out = low_freq_ff;
  assign rc_osc_enable_out = rc_osc_en_ff;
  assign xtal_osc_enable_out = xtal_osc_en_ff;
  assign clock_select_ext_out = active_ext_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  logic [15:0] tail_seen_ff;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tail_seen_ff <= CNT_NONE;
    end else begin
      tail_seen_ff <= (state_ff != ST_TAIL) ? CNT_NONE : (act_edge ? tail_seen_ff + CNT_ONE : tail_seen_ff);
    end
  end

  chk_lf_startup_len: assert property (
    (state_ff == ST_OSC && osc_done && !wake_ff && kind_ff == KIND_LF) |->
      (cnt_ff == (fuse_css[CSS_LSB_BIT] ? 16'(LF_LONG_STARTUP - 1) : CNT_1K - CNT_ONE)))
    else $error("low frequency start-up length wrong");
  chk_tail_fourteen: assert property (
    (state_ff == ST_TAIL && nxt_state != ST_TAIL) |-> (tail_seen_ff == CNT_TAIL - CNT_ONE && act_edge))
    else $error("reset tail not fourteen cycles");
  chk_rc_six_cycles: assert property (
    (osc_done && kind_ff == KIND_RCEXT && !active_ext_ff) |-> (cnt_ff == CNT_RC_EXT_START - CNT_ONE))
    else $error("rc start-up not six cycles");
  chk_long_timeout: assert property (
    (state_ff == ST_TIMEOUT && to_done && kind_ff != KIND_LP && timeout_ff != CNT_TO_SHORT) |->
      (cnt_ff == 16'(LONG_TIMEOUT_CYCLES - 1)))
    else $error("long time-out length wrong");
  chk_wake_no_timeout: assert property (
    (osc_done && wake_ff) |=> (state_ff == ST_RUN) ##1 (state_ff != ST_TIMEOUT))
    else $error("wake path entered time-out");
  chk_wdt_only: assert property (
    (state_ff == ST_TIMEOUT && !wdt_edge && nxt_state == ST_TIMEOUT) |=> $stable(cnt_ff))
    else $error("time-out counted without watchdog edge");
  chk_gate_closed: assert property (
    (!core_rstn_out) |-> ##1 (!core_clk_en_out || $past(running)))
    else $error("core clock ran under reset");
  chk_div_eighth: assert property (
    (core_clk_en_out && div8_ff) |-> ($past(div_ff) == DIV8_LAST))
    else $error("divide-by-eight pulse misplaced");
  chk_trim_factory: assert property (
    latch_done |=> (rc_trim_out == $past(fuse_cal)) ##1 (state_ff == ST_OSC))
    else $error("factory trim not loaded");
  chk_trim_write: assert property (
    (wr_trim && !latch_done) |=> (rc_trim_out == $past(pwdata_in[7:0])))
    else $error("trim write not applied");
  chk_freq_reserved: assert property (
    (first_acc && !pwrite_in && hit_freq) |=> (prdata_out[31:1] == 31'h0 && pready_out))
    else $error("reserved control bits not zero");
  chk_freq_select: assert property (
    (wr_freq && !latch_done) |=> (rc_low_freq_out == $past(pwdata_in[FREQ_LOW_BIT])) && $stable(rc_trim_out))
    else $error("frequency select not applied");
  chk_rc_fuse: assert property (
    (latch_done && fuse_css == CSS_RC) |=> !clock_select_ext_out)
    else $error("rc fuse did not select rc");
  chk_switch_on: assert property (
    ($changed(active_ext_ff) && $past(running)) |->
      (active_ext_ff ? $past(src_on[SRC_EXT]) : $past(src_on[SRC_RC])))
    else $error("switched to a source not running");
  chk_lf_locked: assert property (
    (kind_ff == KIND_LF && state_ff != ST_LATCH) |=> $stable(active_ext_ff))
    else $error("low frequency crystal was switched");

  cov_boot_run: cover property ((state_ff == ST_TIMEOUT) ##1 (state_ff == ST_RUN));
  cov_sleep_wake: cover property ((state_ff == ST_SLEEP) ##1 (state_ff == ST_OSC));
  cov_switch_ext: cover property ($rose(active_ext_ff) && running);
  cov_reserved_code: cover property (latch_done && fuse_sut == SUT_RSVD);

endmodule

// >>> core/ccs_pkg.sv
// ----------------------------------------
// Clock source control constants
// ----------------------------------------
package ccs_pkg;

  localparam int ADDR_W = 12;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_TRIM = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_FREQ = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SWCTRL = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c;

  // Field positions
  localparam int FREQ_LOW_BIT = 0;
  localparam int SW_RC_EN_BIT = 0;
  localparam int SW_EXT_EN_BIT = 1;
  localparam int SW_SEL_EXT_BIT = 2;
  localparam int ST_RC_ON_BIT = 0;
  localparam int ST_EXT_ON_BIT = 1;
  localparam int ST_ACT_EXT_BIT = 2;
  localparam int ST_RUN_BIT = 3;
  localparam int STRB_LOW_LANE = 0;

  // Clock source select fuse codes
  localparam logic [3:0] CSS_RC = 4'h2;
  localparam logic [3:0] CSS_EXT = 4'h0;
  // Low frequency crystal is the pair 010x; bit 0 picks the long start-up
  localparam logic [3:0] CSS_LFXT = 4'h4;
  localparam int CSS_LP_BIT = 3;
  localparam int CSS_LSB_BIT = 0;

  // Source kinds
  localparam logic [1:0] KIND_RCEXT = 2'h0;
  localparam logic [1:0] KIND_LF = 2'h1;
  localparam logic [1:0] KIND_LP = 2'h2;

  // Start-up select codes
  localparam logic [1:0] SUT_ZERO = 2'h0;
  localparam logic [1:0] SUT_SHORT = 2'h1;
  localparam logic [1:0] SUT_LONG = 2'h2;
  localparam logic [1:0] SUT_RSVD = 2'h3;

  // Cycle counts
  localparam logic [15:0] CNT_RC_EXT_START = 16'h0006;
  localparam logic [15:0] CNT_LP_SHORT = 16'h0102;
  localparam logic [15:0] CNT_1K = 16'h0400;
  localparam logic [15:0] CNT_TAIL = 16'h000e;
  localparam logic [15:0] CNT_TO_SHORT = 16'h0200;
  localparam logic [15:0] CNT_SETTLE = 16'h0003;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_NONE = 16'h0000;
  localparam int DEF_LONG_TIMEOUT = 8192;
  localparam int DEF_LF_LONG = 32768;
  localparam int DEF_LP_LONG = 16384;
  localparam logic [2:0] DIV8_LAST = 3'h7;

  // Synchroniser bus layout
  localparam int SB_RC = 0;
  localparam int SB_XTAL = 1;
  localparam int SB_WDT = 2;
  localparam int SB_CSS_LO = 3;
  localparam int SB_SUT_LO = 7;
  localparam int SB_DIV8 = 9;
  localparam int SB_CAL_LO = 10;
  localparam int SYNC_W = 18;

  localparam int SRC_RC = 0;
  localparam int SRC_EXT = 1;
  localparam int SRC_N = 2;

  typedef enum logic [2:0] {ST_LATCH, ST_OSC, ST_TAIL, ST_TIMEOUT, ST_RUN, ST_SLEEP} ccs_state_type;

endpackage

// >>> core/ccs_edge_sync.sv
`timescale 1ns/100ps
// ----------------------------------------
// Two-stage synchroniser with rise detect
// ----------------------------------------
module ccs_edge_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out
);
  import ccs_pkg::*;

  // Edge detect looks only at the second stage
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
        meta_ff <= 1'b0;
        sync_ff <= 1'b0;
        prev_ff <= 1'b0;
      end else begin
        meta_ff <= async_in[g];
        sync_ff <= meta_ff;
        prev_ff <= sync_ff;
      end
    end
    assign level_out[g] = sync_ff;
    assign rise_out[g] = sync_ff & ~prev_ff;
  end

endmodule

// >>> bench/ccs_osc_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Oscillator sources; rc and xtal run only while enabled, the watchdog runs free
// ----------------------------------------
module ccs_osc_model #(
  parameter int RC_NS = 400,
  parameter int XT_NS = 600,
  parameter int WD_NS = 800
) (
  input wire logic rc_en_in,
  input wire logic xtal_en_in,
  output logic rc_out,
  output logic xtal_out,
  output logic wdt_out
);
  initial begin
    rc_out = 1'b0;
    xtal_out = 1'b0;
    wdt_out = 1'b0;
  end
  // Periods stay slow against the system clock, so every edge is seen
  // A disabled oscillator stops low, so a missing enable stalls the count
  always #(RC_NS/2) rc_out = rc_en_in ? ~rc_out : 1'b0;
  always #(XT_NS/2) xtal_out = xtal_en_in ? ~xtal_out : 1'b0;
  always #(WD_NS/2) wdt_out = ~wdt_out;
endmodule

// >>> bench/ccs_clock_source_ctrl_test.sv
`timescale 1ns/100ps
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module ccs_clock_source_ctrl_test;
  import ccs_pkg::*;
  logic clock_in = 1'b0, rstn_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = 4'h0, css = CSS_RC;
  logic [1:0] startup_select = SUT_ZERO;
  logic div8 = 1'b0, sleep = 1'b0, wake = 1'b0, pready, pslverr, rc, xt, wd, clk_en, core_rstn, tick;
  logic lowf, rc_en, xt_en, sel_ext;
  logic [7:0] cal = 8'h00, trim;
  logic [33:0] q[$], e;
  int num_errors = 0, checks = 0, cyc = 0;
  always #50 clock_in = ~clock_in;
  ccs_osc_model ccs_osc_model_inst (.rc_en_in(rc_en), .xtal_en_in(xt_en), .rc_out(rc), .xtal_out(xt),
    .wdt_out(wd));
  ccs_clock_source_ctrl #(.LONG_TIMEOUT_CYCLES(16), .LF_LONG_STARTUP(32), .LP_LONG_STARTUP(32))
    ccs_clock_source_ctrl_inst (.clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr), .rc_osc_in(rc), .xtal_osc_in(xt), .wdt_osc_in(wd),
    .fuse_clock_source_select_in(css), .fuse_startup_select_in(startup_select), .fuse_divide_by_eight_in(div8),
    .factory_cal_in(cal), .sleep_enter_in(sleep), .wake_in(wake), .core_clk_en_out(clk_en),
    .core_rstn_out(core_rstn), .wdt_tick_out(tick), .rc_trim_out(trim), .rc_low_freq_out(lowf),
    .rc_osc_enable_out(rc_en), .xtal_osc_enable_out(xt_en), .clock_select_ext_out(sel_ext));
  task end_sim;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task check(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // Expectation noted at setup, compared when the answer appears
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [31:0] x, input logic er);
    q.push_back({~w, er, x});
    @(posedge clock_in);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, 4'hf};
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge clock_in) if (psel && penable && pready === 1'b1) begin
    e = q.pop_front();
    check({31'h0, pslverr}, {31'h0, e[32]});
    if (e[33]) check(prdata, e[31:0]);
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      end_sim;
    end
  end
  task rst(input logic [3:0] c, input logic [1:0] s, input logic d, output int n);
    rstn_in <= 1'b0;
    {css, startup_select, div8} <= {c, s, d};
    cal <= 8'($urandom);
    repeat (6) @(posedge clock_in);
    rstn_in <= 1'b1;
    n = 0;
    while (core_rstn !== 1'b1) begin
      @(posedge clock_in);
      if (tick === 1'b1) n++;
    end
    check({24'h0, trim}, {24'h0, cal});
  endtask
  task pulses(input int cycles, input int lo, input int hi);
    int n;
    n = 0;
    repeat (cycles) begin
      @(posedge clock_in);
      if (clk_en === 1'b1) n++;
    end
    check({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask
  initial begin
    int t0, t1, x[4];
    logic [31:0] d;
    x = '{0, 512, 16, 16};
    void'($urandom(34683));
    rst(CSS_RC, SUT_ZERO, 1'b0, t0);
    for (int i = 1; i < 4; i++) begin
      rst(CSS_RC, 2'(i), 1'b0, t1);
      check({31'h0, t1 - t0 >= x[i] - 2 && t1 - t0 <= x[i] + 2}, 32'h1);
    end
    apb(1'b0, OFS_FREQ, 32'h0, 32'h0, 1'b0);
    apb(1'b0, OFS_TRIM, 32'h0, {24'h0, cal}, 1'b0);
    repeat (3) begin
      d = {24'h0, 8'($urandom)};
      apb(1'b1, OFS_TRIM, d, 32'h0, 1'b0);
      apb(1'b0, OFS_TRIM, 32'h0, d, 1'b0);
      check({24'h0, trim}, d);
    end
    apb(1'b1, OFS_FREQ, 32'hffffffff, 32'h0, 1'b0);
    apb(1'b0, OFS_FREQ, 32'h0, 32'h1, 1'b0);
    check({31'h0, lowf}, 32'h1);
    apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
    pulses(800, 198, 202);
    apb(1'b1, OFS_SWCTRL, 32'h7, 32'h0, 1'b0);
    repeat (300) @(posedge clock_in);
    check({31'h0, sel_ext}, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0, 32'hf, 1'b0);
    apb(1'b1, OFS_SWCTRL, 32'h1, 32'h0, 1'b0);
    repeat (300) @(posedge clock_in);
    check({31'h0, sel_ext}, 32'h0);
    check({31'h0, xt_en}, 32'h0);
    sleep <= 1'b1;
    @(posedge clock_in);
    sleep <= 1'b0;
    repeat (2) @(posedge clock_in);
    pulses(18, 0, 0);
    wake <= 1'b1;
    @(posedge clock_in);
    wake <= 1'b0;
    t1 = 0;
    while (clk_en !== 1'b1 && t1 < 200) begin
      @(posedge clock_in);
      t1++;
    end
    check({31'h0, t1 >= 20 && t1 <= 34}, 32'h1);
    check({31'h0, core_rstn}, 32'h1);
    rst(CSS_LFXT, SUT_ZERO, 1'b1, t0);
    check({31'h0, t0 >= 776 && t0 <= 782}, 32'h1);
    pulses(1200, 23, 27);
    apb(1'b1, OFS_SWCTRL, 32'h1, 32'h0, 1'b0);
    repeat (300) @(posedge clock_in);
    check({31'h0, sel_ext}, 32'h1);
    rst({CSS_LFXT[3:1], 1'b1}, SUT_ZERO, 1'b1, t1);
    check({31'h0, t1 >= 33 && t1 <= 38}, 32'h1);
    end_sim;
  end
endmodule
